// file: design/iop_ports.sv
`timescale 1ns/1ps
`default_nettype none
module iop_ports (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic mode_wr,
    input wire logic [7:0] mode_wdata,
    input wire logic synth_load,
    input wire logic [13:0] synth_data,
    input wire logic sample_tick,
    input wire logic two_pin_dac,
    input wire logic timer_underflow,
    input wire logic irq1_ack,
    input wire logic irq2_ack,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    output logic [7:0] port_a_pullup,
    input wire logic [1:0] port_b_in,
    output logic [1:0] port_b_out,
    output logic [1:0] port_b_oe,
    output logic [1:0] port_b_pullup,
    input wire logic ext_clk_in,
    input wire logic ext_strobe_in,
    input wire logic [3:0] ext_data_out,
    input wire logic [3:0] ext_data_oe,
    output logic [7:0] host_input_latch,
    output logic host_write_seen,
    output logic [13:0] pitch_reg,
    output logic [13:0] converter_reg,
    output logic [13:0] excitation_reg,
    output logic noise_excite,
    output logic fetch_from_ram,
    output logic fetch_ext_rom,
    output logic [3:0] synth_mode,
    output logic [6:0] synth_share,
    output logic lvl1_irq,
    output logic lvl2_irq
);
    iop_mode_if mif();

    logic [7:0] mode;
    logic [7:0] next_mode;
    logic [7:0] a_pull, a_dir, a_lat, next_a_pull, next_a_dir, next_a_lat;
    logic [1:0] b_pull, b_dir, b_lat, next_b_pull, next_b_dir, next_b_lat;
    logic [7:0] next_rdata, next_host_in;
    logic next_host_seen;
    logic [13:0] next_pitch, next_conv, next_exc;
    logic pend1, pend2, next_pend1, next_pend2;
    logic next_irq1, next_irq2;
    logic [7:0] next_a_out, next_a_oe, next_a_pu;
    logic [1:0] next_b_out, next_b_oe, next_b_pu;
    logic [6:0] next_share;
    logic next_noise, next_ram, next_ext;
    iop_pkg::iop_synth_type syn, next_syn;
    logic slave, host_ce, host_read, host_write;

    assign mif.mode = mode;

    iop_synth_timing i_iop_synth_timing (
        .mclk(mclk),
        .rst_n(rst_n),
        .mif(mif),
        .b1_level(port_b_in[1]),
        .sample_tick(sample_tick),
        .pitch_value(pitch_reg),
        .div_count()
    );

    // ----------------------------------------------------------------
    // Pin drive decode
    // ----------------------------------------------------------------
    function automatic logic [2:0] pin_drive(input logic dir, input logic pull,
                                             input logic lat);
        // Returns out, enable, pullup.
        if (dir) begin
            return pull ? {1'b0, ~lat, 1'b0} : {lat, 1'b1, 1'b0};
        end
        return {1'b0, 1'b0, pull};
    endfunction

    // Port B pad to eight bits.
    function automatic logic [7:0] widen_b(input logic [1:0] v);
        return {6'h00, v};
    endfunction

    // ----------------------------------------------------------------
    // Host slave decode
    // ----------------------------------------------------------------
    // Slave decode.
    assign slave = mode[iop_pkg::MODE_IO_OWNER];
    assign host_ce = slave && !port_b_in[0];
    assign host_read = host_ce && port_b_in[1];
    assign host_write = host_ce && !port_b_in[1];

    // ----------------------------------------------------------------
    // Register file and host access
    // ----------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        next_a_pull = a_pull;
        next_a_dir = a_dir;
        next_a_lat = a_lat;
        next_b_pull = b_pull;
        next_b_dir = b_dir;
        next_b_lat = b_lat;
        next_host_in = host_input_latch;
        next_host_seen = 1'b0;
        next_pitch = pitch_reg;
        next_conv = converter_reg;
        next_exc = excitation_reg;
        next_rdata = reg_rdata;
        if (mode_wr) begin
            next_mode = mode_wdata;
        end
        if (reg_wr) begin
            case (reg_addr)
                iop_pkg::PORT_A_PULL_SELECT: next_a_pull = reg_wdata;
                iop_pkg::PORT_A_DIRECTION: next_a_dir = reg_wdata;
                iop_pkg::PORT_A_OUTPUT_LATCH: next_a_lat = reg_wdata;
                iop_pkg::PORT_B_PULL_SELECT: next_b_pull = reg_wdata[1:0];
                iop_pkg::PORT_B_DIRECTION: next_b_dir = reg_wdata[1:0];
                iop_pkg::PORT_B_OUTPUT_LATCH: next_b_lat = reg_wdata[1:0];
                default: next_mode = next_mode;
            endcase
        end
        // Host write capture and handshake clear.
        if (host_write) begin
            next_host_in = port_a_in;
            next_host_seen = 1'b1;
            next_a_lat[iop_pkg::HANDSHAKE_BIT] = 1'b0;
        end
        if (reg_rd) begin
            case (reg_addr)
                iop_pkg::PORT_A_PIN_LEVEL: next_rdata = port_a_in;
                iop_pkg::PORT_A_PULL_SELECT: next_rdata = a_pull;
                iop_pkg::PORT_A_DIRECTION: next_rdata = a_dir;
                iop_pkg::PORT_A_OUTPUT_LATCH: next_rdata = a_lat;
                iop_pkg::PORT_B_PIN_LEVEL: next_rdata = widen_b(port_b_in);
                iop_pkg::PORT_B_PULL_SELECT: next_rdata = widen_b(b_pull);
                iop_pkg::PORT_B_DIRECTION: next_rdata = widen_b(b_dir);
                iop_pkg::PORT_B_OUTPUT_LATCH: next_rdata = widen_b(b_lat);
                default: next_rdata = 8'h00;
            endcase
        end
        // Off and lattice modes load pitch.
        if (synth_load) begin
            case (next_syn)
                iop_pkg::IOP_SYN_RAW: next_conv = synth_data;
                iop_pkg::IOP_SYN_BOTH: next_exc = synth_data;
                default: next_pitch = synth_data;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Mode decode and interrupts
    // ----------------------------------------------------------------
    always_comb begin
        next_syn = iop_pkg::IOP_SYN_OFF;
        next_share = 7'h00;
        case ({mode[iop_pkg::MODE_RAW_SAMPLE], mode[iop_pkg::MODE_LATTICE_SYNTH]})
            2'b01: begin
                next_syn = iop_pkg::IOP_SYN_LATTICE;
                next_share = iop_pkg::SHARE_LATTICE;
            end
            2'b10: next_syn = iop_pkg::IOP_SYN_RAW;
            2'b11: begin
                next_syn = iop_pkg::IOP_SYN_BOTH;
                next_share = iop_pkg::SHARE_BOTH;
            end
            default: next_syn = iop_pkg::IOP_SYN_OFF;
        endcase
        // Pending latches, set wins over acknowledge.
        next_pend1 = mif.lvl1_event || (pend1 && !irq1_ack);
        next_pend2 = timer_underflow || (pend2 && !irq2_ack);
        next_irq1 = next_pend1 && mode[iop_pkg::MODE_LVL1_IRQ_EN];
        // Level 2 yields to level 1.
        next_irq2 = next_pend2 && mode[iop_pkg::MODE_LVL2_IRQ_EN] && !next_irq1;
        // Noise only in lattice without raw.
        next_noise = mode[iop_pkg::MODE_UNVOICED] && next_syn == iop_pkg::IOP_SYN_LATTICE;
        next_ram = mode[iop_pkg::MODE_GET_SOURCE_RAM];
        next_ext = !mode[iop_pkg::MODE_GET_SOURCE_RAM] && mode[iop_pkg::MODE_EXT_STORE];
    end

    // ----------------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] d;
        d = 3'h0;
        for (int i = 0; i < 8; i++) begin
            d = pin_drive(a_dir[i], a_pull[i], a_lat[i]);
            next_a_out[i] = d[2];
            next_a_oe[i] = d[1];
            next_a_pu[i] = d[0];
        end
        for (int i = 0; i < iop_pkg::PORT_B_BITS; i++) begin
            d = pin_drive(b_dir[i], b_pull[i], b_lat[i]);
            next_b_out[i] = d[2];
            next_b_oe[i] = d[1];
            next_b_pu[i] = d[0];
        end
        if (slave) begin
            next_a_out = a_lat;
            next_a_oe = host_read ? 8'hff : 8'h00;
            next_b_oe = 2'b00;
            next_b_out = 2'b00;
        end
        // External store strobe, clock and nibble.
        if (mode[iop_pkg::MODE_EXT_STORE]) begin
            next_b_out[0] = ext_strobe_in;
            next_b_oe[0] = 1'b1;
            next_a_out[7] = ext_clk_in;
            next_a_oe[7] = 1'b1;
            next_a_out[3:0] = ext_data_out;
            next_a_oe[3:0] = ext_data_oe;
        end
        if (two_pin_dac) begin
            next_b_oe[1] = 1'b0;
            next_b_pu[1] = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode <= iop_pkg::MODE_RESET;
            a_pull <= iop_pkg::LATCH_RESET;
            a_dir <= iop_pkg::LATCH_RESET;
            a_lat <= iop_pkg::LATCH_RESET;
            b_pull <= 2'h0;
            b_dir <= 2'h0;
            b_lat <= 2'h0;
            reg_rdata <= 8'h00;
            host_input_latch <= 8'h00;
            host_write_seen <= 1'b0;
            pitch_reg <= 14'h0000;
            converter_reg <= 14'h0000;
            excitation_reg <= 14'h0000;
            pend1 <= 1'b0;
            pend2 <= 1'b0;
            lvl1_irq <= 1'b0;
            lvl2_irq <= 1'b0;
            port_a_out <= 8'h00;
            port_a_oe <= 8'h00;
            port_a_pullup <= 8'h00;
            port_b_out <= 2'h0;
            port_b_oe <= 2'h0;
            port_b_pullup <= 2'h0;
            syn <= iop_pkg::IOP_SYN_OFF;
            synth_share <= 7'h00;
            noise_excite <= 1'b0;
            fetch_from_ram <= 1'b0;
            fetch_ext_rom <= 1'b0;
        end else begin
            mode <= next_mode;
            a_pull <= next_a_pull;
            a_dir <= next_a_dir;
            a_lat <= next_a_lat;
            b_pull <= next_b_pull;
            b_dir <= next_b_dir;
            b_lat <= next_b_lat;
            reg_rdata <= next_rdata;
            host_input_latch <= next_host_in;
            host_write_seen <= next_host_seen;
            pitch_reg <= next_pitch;
            converter_reg <= next_conv;
            excitation_reg <= next_exc;
            pend1 <= next_pend1;
            pend2 <= next_pend2;
            lvl1_irq <= next_irq1;
            lvl2_irq <= next_irq2;
            port_a_out <= next_a_out;
            port_a_oe <= next_a_oe;
            port_a_pullup <= next_a_pu;
            port_b_out <= next_b_out;
            port_b_oe <= next_b_oe;
            port_b_pullup <= next_b_pu;
            syn <= next_syn;
            synth_share <= next_share;
            noise_excite <= next_noise;
            fetch_from_ram <= next_ram;
            fetch_ext_rom <= next_ext;
        end
    end

    // ----------------------------------------------------------------
    // Mode outputs
    // ----------------------------------------------------------------
    // Bit order is carried by the package field positions.
    assign synth_mode = syn;
endmodule
`default_nettype wire

// file: design/iop_pkg.sv
package iop_pkg;
    // ----------------------------------------------------------------
    // Register locations
    // ----------------------------------------------------------------
    localparam logic [7:0] PORT_A_PIN_LEVEL = 8'h80;
    localparam logic [7:0] PORT_A_PULL_SELECT = 8'h81;
    localparam logic [7:0] PORT_A_DIRECTION = 8'h82;
    localparam logic [7:0] PORT_A_OUTPUT_LATCH = 8'h83;
    localparam logic [7:0] PORT_B_PIN_LEVEL = 8'h84;
    localparam logic [7:0] PORT_B_PULL_SELECT = 8'h85;
    localparam logic [7:0] PORT_B_DIRECTION = 8'h86;
    localparam logic [7:0] PORT_B_OUTPUT_LATCH = 8'h87;
    // ----------------------------------------------------------------
    // Mode register fields
    // ----------------------------------------------------------------
    localparam int MODE_LVL1_IRQ_EN = 0;
    localparam int MODE_LATTICE_SYNTH = 1;
    localparam int MODE_RAW_SAMPLE = 2;
    localparam int MODE_LVL2_IRQ_EN = 3;
    localparam int MODE_EXT_STORE = 4;
    localparam int MODE_GET_SOURCE_RAM = 5;
    localparam int MODE_IO_OWNER = 6;
    localparam int MODE_UNVOICED = 7;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam int PORT_B_BITS = 2;
    localparam int HANDSHAKE_BIT = 7;
    // ----------------------------------------------------------------
    // Timing: oscillator divides and pitch threshold
    // ----------------------------------------------------------------
    localparam int RAW_DIVIDE = 480;
    localparam int BOTH_DIVIDE = 960;
    localparam logic [13:0] PITCH_IRQ_LIMIT = 14'h0200;
    localparam logic [13:0] PITCH_STEP = 14'h0020;
    localparam logic [9:0] RAW_COUNT = 10'(RAW_DIVIDE - 1);
    localparam logic [9:0] BOTH_COUNT = 10'(BOTH_DIVIDE - 1);
    // Synthesizer share: cycles out of 100 and 50 out of 100.
    localparam logic [6:0] SHARE_LATTICE = 7'h35;
    localparam logic [6:0] SHARE_BOTH = 7'h32;

    typedef enum logic [3:0] {
        IOP_SYN_OFF = 4'h1,
        IOP_SYN_LATTICE = 4'h2,
        IOP_SYN_RAW = 4'h4,
        IOP_SYN_BOTH = 4'h8
    } iop_synth_type;
endpackage

// file: design/iop_mode_if.sv
`timescale 1ns/1ps
`default_nettype none
interface iop_mode_if;
    logic [7:0] mode;
    logic lvl1_event;
    modport ctl(output mode, input lvl1_event);
    modport gen(input mode, output lvl1_event);
endinterface
`default_nettype wire

// file: design/iop_synth_timing.sv
`timescale 1ns/1ps
`default_nettype none
module iop_synth_timing (
    input wire logic mclk,
    input wire logic rst_n,
    iop_mode_if.gen mif,
    input wire logic b1_level,
    input wire logic sample_tick,
    input wire logic [13:0] pitch_value,
    output logic [9:0] div_count
);
    logic [9:0] next_div_count;
    logic b1_prev;
    logic next_b1_prev;
    logic [13:0] pitch_ctr;
    logic [13:0] next_pitch_ctr;
    logic next_event;
    logic event_r;
    logic raw;
    logic lat;
    logic [13:0] dec;

    assign raw = mif.mode[iop_pkg::MODE_RAW_SAMPLE];
    assign lat = mif.mode[iop_pkg::MODE_LATTICE_SYNTH];
    assign mif.lvl1_event = event_r;

    always_comb begin
        next_div_count = div_count + 10'h001;
        next_b1_prev = b1_level;
        next_pitch_ctr = pitch_ctr;
        next_event = 1'b0;
        dec = pitch_ctr - iop_pkg::PITCH_STEP;
        if (!raw) begin
            next_div_count = 10'h000;
        end
        if (raw && !lat && div_count >= iop_pkg::RAW_COUNT) begin
            next_div_count = 10'h000;
            next_event = 1'b1;
        end
        if (raw && lat && div_count >= iop_pkg::BOTH_COUNT) begin
            next_div_count = 10'h000;
            next_event = 1'b1;
        end
        if (!raw && !lat && b1_prev && !b1_level) begin
            next_event = 1'b1;
        end
        if (!raw && lat && sample_tick) begin
            if (pitch_ctr < iop_pkg::PITCH_STEP) begin
                next_pitch_ctr = dec + pitch_value;
            end else begin
                next_pitch_ctr = dec;
            end
            if (next_pitch_ctr < iop_pkg::PITCH_IRQ_LIMIT) begin
                next_event = 1'b1;
            end
        end
        if (!lat) begin
            next_pitch_ctr = 14'h0000;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_count <= 10'h000;
            b1_prev <= 1'b1;
            pitch_ctr <= 14'h0000;
            event_r <= 1'b0;
        end else begin
            div_count <= next_div_count;
            b1_prev <= next_b1_prev;
            pitch_ctr <= next_pitch_ctr;
            event_r <= next_event;
        end
    end
endmodule
`default_nettype wire

// file: tb/iop_ports_properties.sv
`timescale 1ns/1ps
`default_nettype none
module iop_ports_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic mode_wr,
    input wire logic [7:0] mode_wdata,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_a_oe,
    input wire logic [1:0] port_b_in,
    input wire logic [1:0] port_b_oe,
    input wire logic [7:0] host_input_latch,
    input wire logic host_write_seen,
    input wire logic noise_excite,
    input wire logic fetch_from_ram,
    input wire logic [3:0] synth_mode,
    input wire logic [6:0] synth_share,
    input wire logic lvl2_irq
);
    logic [7:0] mode;
    logic [7:0] next_mode;
    always_comb begin
        next_mode = mode;
        if (!rst_n)
            next_mode = 8'h00;
        else if (mode_wr)
            next_mode = mode_wdata;
    end
    always_ff @(posedge mclk) begin
        mode <= next_mode;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    chk_unmapped_zero: assert property (
        reg_rd && reg_addr[7:3] != 5'h10 |=> reg_rdata == 8'h00) else $error("bad unmapped read");
    chk_b_upper_zero: assert property (
        reg_rd && reg_addr[7:2] == 6'h21 |=> reg_rdata[7:2] == 6'h00) else $error("bad b upper");
    chk_pin_level: assert property (
        reg_rd && reg_addr == 8'h80 |=> reg_rdata == $past(port_a_in)) else $error("bad pin read");
    chk_host_capture: assert property (
        mode[6] && port_b_in == 2'b00 |=> host_write_seen && host_input_latch == $past(port_a_in))
        else $error("bad host capture");
    chk_host_read: assert property (
        mode[6] && port_b_in == 2'b10 |=> port_a_oe == 8'hff) else $error("bad host read");
    chk_slave_b_in: assert property (
        mode[6] |=> port_b_oe == 2'b00) else $error("b drives in slave");
    chk_both_mode: assert property (
        mode_wr && mode_wdata[2:1] == 2'b11 |-> ##2 synth_mode == 4'h8 && synth_share == 7'h32)
        else $error("bad both mode");
    chk_lattice_noise: assert property (
        mode_wr && mode_wdata[2:1] == 2'b01 |-> ##2 noise_excite == $past(mode_wdata[7], 2))
        else $error("bad noise select");
    chk_fetch_source: assert property (
        mode_wr |-> ##2 fetch_from_ram == $past(mode_wdata[5], 2)) else $error("bad fetch source");
    chk_lvl2_masked: assert property (
        lvl2_irq |-> $past(mode[3])) else $error("lvl2 while masked");
endmodule
bind iop_ports iop_ports_checker i_iop_ports_checker (
    .mclk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .mode_wr, .mode_wdata, .port_a_in,
    .port_a_oe, .port_b_in, .port_b_oe, .host_input_latch, .host_write_seen,
    .noise_excite, .fetch_from_ram, .synth_mode, .synth_share, .lvl2_irq
);
`default_nettype wire

// file: tb/iop_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module iop_host_model (
    input wire logic mclk,
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe,
    input wire logic [7:0] port_a_pullup,
    input wire logic [1:0] port_b_out,
    input wire logic [1:0] port_b_oe,
    input wire logic [1:0] port_b_pullup,
    input wire logic [7:0] host_a_oe,
    input wire logic [7:0] host_a_val,
    input wire logic [1:0] host_b_oe,
    input wire logic [1:0] host_b_val,
    output logic [7:0] port_a_in,
    output logic [1:0] port_b_in
);
    logic [7:0] float_pat = 8'h69;
    always_ff @(posedge mclk) begin
        float_pat <= ~float_pat;
    end
    // undriven lines pull up or float.
    assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & host_a_oe & host_a_val)
        | (~port_a_oe & ~host_a_oe & (port_a_pullup | float_pat));
    assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & host_b_oe & host_b_val)
        | (~port_b_oe & ~host_b_oe & (port_b_pullup | float_pat[1:0]));
endmodule
`default_nettype wire

// file: tb/iop_ports_test.sv
`timescale 1ns/1ps
`default_nettype none
module iop_ports_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_rd = 1'b0, reg_wr = 1'b0, mode_wr = 1'b0, synth_load = 1'b0;
    logic sample_tick = 1'b0, timer_underflow = 1'b0, irq1_ack = 1'b0, irq2_ack = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, mode_wdata = 8'h00;
    logic [7:0] host_a_oe = 8'h00, host_a_val = 8'h00;
    logic [1:0] host_b_oe = 2'b00, host_b_val = 2'b00;
    logic [13:0] synth_data = 14'h0000;
    logic two_pin_dac = 1'b0, ext_clk_in = 1'b0, ext_strobe_in = 1'b0;
    logic [3:0] ext_data_out = 4'h0, ext_data_oe = 4'h0;
    logic [7:0] reg_rdata, port_a_in, port_a_out, port_a_oe, port_a_pullup, host_input_latch;
    logic [1:0] port_b_in, port_b_out, port_b_oe, port_b_pullup;
    logic [13:0] pitch_reg, converter_reg, excitation_reg;
    logic [3:0] synth_mode;
    logic [6:0] synth_share;
    logic host_write_seen, noise_excite, fetch_from_ram, fetch_ext_rom, lvl1_irq, lvl2_irq;
    int error_cnt = 0;
    int tests_run = 0;
    int n;
    always #5 mclk = ~mclk;
    iop_ports i_iop_ports (.*);
    iop_host_model i_iop_host_model (.*);
    task automatic cmp(input string what, input logic [13:0] exp, input logic [13:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge mclk);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        pulse(reg_wr);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        pulse(reg_rd);
        cmp($sformatf("reg %h", a), 14'(exp), 14'(reg_rdata));
    endtask
    task automatic setmode(input logic [7:0] m);
        mode_wdata = m;
        pulse(mode_wr);
        @(negedge mclk);
    endtask
    task automatic wait_irq(input logic v, input int lim);
        while (lvl1_irq !== v && n < lim) begin
            @(negedge mclk);
            n++;
        end
    endtask
    task automatic pin_case(input logic [7:0] dir, pull, lat, hoe, hval);
        logic [7:0] eoe;
        eoe = dir & (~pull | ~lat);
        host_a_oe = hoe;
        host_a_val = hval;
        wr(8'h81, pull);
        wr(8'h82, dir);
        wr(8'h83, lat);
        @(negedge mclk);
        cmp("a oe", 14'(eoe), 14'(port_a_oe));
        cmp("a out", 14'(lat & eoe), 14'(port_a_out & port_a_oe));
        cmp("a pullup", 14'(~dir & pull), 14'(port_a_pullup));
        rdc(8'h80, (eoe & lat) | (~eoe & hoe & hval) | (~eoe & ~hoe & ~dir & pull));
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        close_out;
    end
    initial begin
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        for (int i = 1; i < 8; i++) begin
            if (i != 4) begin
                rdc(8'h80 | 8'(i), 8'h00);
                wr(8'h80 | 8'(i), 8'hc4 ^ 8'(i));
                rdc(8'h80 | 8'(i), (8'hc4 ^ 8'(i)) & (i > 4 ? 8'h03 : 8'hff));
            end
        end
        wr(8'h89, 8'hff);
        rdc(8'h81, 8'hc5);
        rdc(8'h88, 8'h00);
        pin_case(8'hff, 8'h00, 8'ha5, 8'h00, 8'h00);
        pin_case(8'hff, 8'hff, 8'ha5, 8'ha5, 8'hff);
        pin_case(8'h00, 8'hff, 8'h00, 8'h00, 8'h00);
        pin_case(8'h00, 8'h00, 8'h00, 8'hff, 8'h3c);
        wr(8'h85, 8'h02);
        wr(8'h86, 8'h01);
        wr(8'h87, 8'h01);
        rdc(8'h84, 8'h03);
        host_a_oe = 8'h00;
        host_b_oe = 2'b11;
        host_b_val = 2'b11;
        wr(8'h82, 8'h00);
        wr(8'h86, 8'h00);
        wr(8'h83, 8'h8c);
        setmode(8'h40);
        host_a_oe = 8'hff;
        host_a_val = 8'h3c;
        host_b_val = 2'b00;
        @(negedge mclk);
        host_b_val = 2'b11;
        cmp("write seen", 14'h1, 14'(host_write_seen));
        cmp("host latch", 14'h3c, 14'(host_input_latch));
        host_a_oe = 8'h00;
        rdc(8'h83, 8'h0c);
        host_b_val = 2'b10;
        repeat (2) @(negedge mclk);
        cmp("read data", 14'h0c, 14'(port_a_out));
        host_b_val = 2'b11;
        for (int m = 0; m < 4; m++) begin
            setmode({m[0], 1'b0, m[1], 2'b00, 2'(m), 1'b0});
            synth_data = 14'h1000 | 14'(m);
            pulse(synth_load);
            cmp("fetch ram", 14'(m[1]), 14'(fetch_from_ram));
            case (m)
                2: cmp("converter", synth_data, converter_reg);
                3: cmp("excitation", synth_data, excitation_reg);
                default: cmp("pitch", synth_data, pitch_reg);
            endcase
        end
        for (int k = 0; k < 2; k++) begin
            setmode(k ? 8'h07 : 8'h05);
            pulse(irq1_ack);
            n = 0;
            wait_irq(1'b1, 3000);
            pulse(irq1_ack);
            n = 2;
            wait_irq(1'b0, 50);
            wait_irq(1'b1, 3000);
            cmp("period", 14'(k ? iop_pkg::BOTH_DIVIDE : iop_pkg::RAW_DIVIDE), 14'(n));
        end
        setmode(8'h01);
        pulse(irq1_ack);
        repeat (4) @(negedge mclk);
        cmp("b1 idle", 14'h0, 14'(lvl1_irq));
        host_b_val = 2'b01;
        n = 0;
        wait_irq(1'b1, 10);
        cmp("b1 fall", 14'h1, 14'(lvl1_irq));
        setmode(8'h03);
        synth_data = 14'h0400;
        pulse(synth_load);
        pulse(irq1_ack);
        repeat (3) @(negedge mclk);
        for (n = 0; n < 60 && lvl1_irq !== 1'b1; n++)
            pulse(sample_tick);
        cmp("pitch irq", 14'h1, 14'(lvl1_irq));
        setmode(8'h00);
        pulse(irq2_ack);
        pulse(timer_underflow);
        repeat (4) @(negedge mclk);
        cmp("lvl2 masked", 14'h0, 14'(lvl2_irq));
        setmode(8'h08);
        repeat (3) @(negedge mclk);
        cmp("lvl2 taken", 14'h1, 14'(lvl2_irq));
        pulse(irq2_ack);
        repeat (3) @(negedge mclk);
        cmp("lvl2 clear", 14'h0, 14'(lvl2_irq));
        ext_clk_in = 1'b1;
        ext_strobe_in = 1'b1;
        ext_data_out = 4'ha;
        ext_data_oe = 4'hf;
        setmode(8'h10);
        cmp("ext a oe", 14'h8f, 14'(port_a_oe & 8'h8f));
        cmp("ext a out", 14'h8a, 14'(port_a_out & 8'h8f));
        cmp("ext b0", 14'h3, 14'({port_b_oe[0], port_b_out[0]}));
        cmp("ext fetch", 14'h1, 14'(fetch_ext_rom));
        two_pin_dac = 1'b1;
        wr(8'h86, 8'h02);
        @(negedge mclk);
        cmp("b1 released", 14'h0, 14'({port_b_oe[1], port_b_pullup[1]}));
        setmode(8'h26);
        rst_n = 1'b0;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        cmp("ram after init", 14'h0, 14'(fetch_from_ram));
        cmp("share after init", 14'h0, 14'(synth_share));
        rdc(8'h83, 8'h00);
        close_out;
    end
endmodule
`default_nettype wire
